// ===== rtl/bfp_pkg.sv
// constants, carrier types and helpers for the bidirectional fifo port control
// ============================================================
`default_nettype none
package bfp_pkg;
  // ============================================================
  // geometry
  localparam int unsigned DATA_W = 36;
  localparam int unsigned LANE_W = 9;
  localparam int unsigned FIFO_DEPTH = 64;
  localparam int unsigned FIFO_AW = 6;
  localparam logic [6:0] FIFO_FULL_CNT = 7'h40;
  // ============================================================
  // almost-full / almost-empty offset presets, by pick inputs
  localparam logic [6:0] OFFSET_PRESET_LL = 7'h04;
  localparam logic [6:0] OFFSET_PRESET_LH = 7'h08;
  localparam logic [6:0] OFFSET_PRESET_HL = 7'h0c;
  localparam logic [6:0] OFFSET_PRESET_HH = 7'h10;
  // ============================================================
  // port b size codes {width_sel_1, width_sel_0}
  localparam logic [1:0] SIZE_LONG = 2'h0;
  localparam logic [1:0] SIZE_BYTE = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;
  localparam logic [1:0] SIZE_MAIL = 2'h3;
  // swap codes {swap_sel_1, swap_sel_0}
  localparam logic [1:0] SWAP_NONE = 2'h0;
  localparam logic [1:0] SWAP_BYTE = 2'h1;
  localparam logic [1:0] SWAP_WORD = 2'h2;
  localparam logic [1:0] SWAP_BYTE_WORD = 2'h3;
  // ============================================================
  // flag group of one port (all active low)
  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic aempty_n;
    logic afull_n;
  } bfp_flags_t;
  // flag values while in reset
  localparam bfp_flags_t FLAGS_RST = 4'h1;
  // ============================================================
  // fill generated parity into the top bit of every lane
  function automatic logic [35:0] bfp_par_fill(input logic [35:0] w,
                                               input logic odd);
    logic [35:0] r;
    r = w;
    for (int i = 0; i < 4; i++)
    begin
      r[i*9+8] = (^w[i*9 +: 8]) ^ odd;
    end
    return r;
  endfunction
  // any lane up to last failing the selected parity sense
  function automatic logic bfp_lane_fail(input logic [35:0] w,
                                         input logic odd,
                                         input logic [1:0] last);
    logic f;
    f = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      if (i <= int'(last) && ((^w[i*9 +: 9]) != odd))
      begin
        f = 1'b1;
      end
    end
    return f;
  endfunction
  // byte order swap of a long word, lanes kept whole
  function automatic logic [35:0] bfp_swap(input logic [35:0] w,
                                           input logic [1:0] m);
    logic [35:0] r;
    case (m)
      SWAP_BYTE: r = {w[8:0], w[17:9], w[26:18], w[35:27]};
      SWAP_WORD: r = {w[17:0], w[35:18]};
      SWAP_BYTE_WORD: r = {w[26:18], w[35:27], w[8:0], w[17:9]};
      default: r = w;
    endcase
    return r;
  endfunction
  // index of the last lane of a long word for a bus size
  function automatic logic [1:0] bfp_last_lane(input logic [1:0] s);
    logic [1:0] r;
    case (s)
      SIZE_BYTE: r = 2'h3;
      SIZE_WORD: r = 2'h1;
      default: r = 2'h0;
    endcase
    return r;
  endfunction
endpackage
`default_nettype wire

// ===== rtl/bfp_mem.sv
// one fifo array: one write port, one read port with registered data
`timescale 1ns/1ps
`default_nettype none
module bfp_mem #(
  parameter int unsigned W = 36,
  parameter int unsigned AW = 6
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  // ============================================================
  // storage
  logic [W-1:0] mem_r [0:(1<<AW)-1]; // word array, no reset
  logic [W-1:0] rd_data_r; // output register

  // write port
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // read port, holds last word until the next read
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data_r <= '0;
    end
    else if (rd_en)
    begin
      rd_data_r <= mem_r[rd_addr];
    end
  end

  assign rd_data = rd_data_r;
endmodule
`default_nettype wire

// ===== rtl/bfp_port_ctrl.sv
// two-port fifo control: access decode, sizing, swap, parity, flags
`timescale 1ns/1ps
`default_nettype none
module bfp_port_ctrl
  import bfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic odd_parity_sel,
  input wire logic offset_pick_0,
  input wire logic offset_pick_1,
  // port a
  input wire logic a_chip_select_n,
  input wire logic a_write_not_read,
  input wire logic a_port_go,
  input wire logic a_mailbox_select,
  input wire logic a_parity_gen_on,
  input wire logic [35:0] a_din,
  output logic [35:0] a_dout,
  output logic a_doe,
  output logic a_side_full_n,
  output logic a_side_empty_n,
  output logic a_side_almost_empty_n,
  output logic a_side_almost_full_n,
  output logic a_side_parity_fault_n,
  // port b
  input wire logic b_chip_select_n,
  input wire logic b_write_not_read,
  input wire logic b_port_go,
  input wire logic b_width_sel_0,
  input wire logic b_width_sel_1,
  input wire logic big_endian_sel,
  input wire logic swap_sel_0,
  input wire logic swap_sel_1,
  input wire logic b_parity_gen_on,
  input wire logic [35:0] b_din,
  output logic [35:0] b_dout,
  output logic b_doe,
  output logic b_side_full_n,
  output logic b_side_empty_n,
  output logic b_side_almost_empty_n,
  output logic b_side_almost_full_n,
  output logic b_side_parity_fault_n,
  // mailbox flags
  output logic a_to_b_mail_full_n,
  output logic b_to_a_mail_full_n
);
  // ============================================================
  // state of the whole block
  typedef struct packed {
    logic [6:0] ab_wp; // a-to-b queue write pointer
    logic [6:0] ab_rp; // a-to-b queue read pointer
    logic [6:0] ba_wp; // b-to-a queue write pointer
    logic [6:0] ba_rp; // b-to-a queue read pointer
    logic [6:0] ofs; // almost offset x
    logic ofs_loaded; // offset taken after reset release
    bfp_flags_t a_s1; // port a flags, first stage
    bfp_flags_t a_s2; // port a flags, second stage
    bfp_flags_t b_s1; // port b flags, first stage
    bfp_flags_t b_s2; // port b flags, second stage
    logic [35:0] mail1; // a-to-b mailbox
    logic [35:0] mail2; // b-to-a mailbox
    logic mail1_full_n; // a-to-b mailbox flag
    logic mail2_full_n; // b-to-a mailbox flag
    logic [35:0] a_dout; // port a output data
    logic [35:0] b_dout; // port b output data
    logic a_doe; // port a drive
    logic b_doe; // port b drive
    logic a_pfault_n; // port a parity fault
    logic b_pfault_n; // port b parity fault
    logic [2:0] size_cap; // captured {b_width_sel_1, b_width_sel_0, endian}
    logic [2:0] size_app; // applied {b_width_sel_1, b_width_sel_0, endian}
    logic [1:0] rd_lane; // port b lane being presented
    logic [1:0] rd_swap; // swap of the long word being read
    logic [1:0] wr_lane; // port b lane next written
    logic [1:0] wr_swap; // swap of the long word being written
    logic [35:0] wr_hold; // port b long word being assembled
  } bfp_state_t;

  // values forced while reset is low
  localparam bfp_state_t ST_RST = '{
    ofs: OFFSET_PRESET_LL,
    a_s1: FLAGS_RST, a_s2: FLAGS_RST,
    b_s1: FLAGS_RST, b_s2: FLAGS_RST,
    mail1_full_n: 1'b1, mail2_full_n: 1'b1,
    a_pfault_n: 1'b1, b_pfault_n: 1'b1,
    rd_lane: 2'h3,
    default: '0
  };

  bfp_state_t st_r; // registered state
  bfp_state_t st_nxt; // next state

  // ============================================================
  // memory hookup
  logic ab_push; // write into a-to-b queue
  logic ab_pop; // read from a-to-b queue
  logic ba_push; // write into b-to-a queue
  logic ba_pop; // read from b-to-a queue
  logic [35:0] ba_wdata; // assembled port b word
  logic [35:0] ab_rdata; // a-to-b output register
  logic [35:0] ba_rdata; // b-to-a output register

  bfp_mem #(.W(DATA_W), .AW(FIFO_AW)) u_ab_mem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(ab_push),
    .wr_addr(st_r.ab_wp[5:0]),
    .wr_data(a_din),
    .rd_en(ab_pop),
    .rd_addr(st_r.ab_rp[5:0]),
    .rd_data(ab_rdata)
  );

  bfp_mem #(.W(DATA_W), .AW(FIFO_AW)) u_ba_mem (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wr_en(ba_push),
    .wr_addr(st_r.ba_wp[5:0]),
    .wr_data(ba_wdata),
    .rd_en(ba_pop),
    .rd_addr(st_r.ba_rp[5:0]),
    .rd_data(ba_rdata)
  );

  // ============================================================
  // next-state logic
  always_comb
  begin
    logic [6:0] ab_cnt;
    logic [6:0] ba_cnt;
    logic a_wr;
    logic a_rd;
    logic b_wr;
    logic b_rd;
    logic b_mail;
    logic [1:0] size;
    logic [1:0] last;
    logic [1:0] chk;
    logic [1:0] swap_live;
    logic [1:0] swap_eff;
    logic [1:0] lane_eff;
    logic [35:0] hold;
    logic [35:0] word;
    logic [35:0] pick;
    st_nxt = st_r;
    ab_push = 1'b0;
    ab_pop = 1'b0;
    ba_push = 1'b0;
    ba_pop = 1'b0;
    ab_cnt = st_r.ab_wp - st_r.ab_rp;
    ba_cnt = st_r.ba_wp - st_r.ba_rp;
    // a transfer only with chip select low and go high
    a_wr = !a_chip_select_n && a_port_go && a_write_not_read;
    a_rd = !a_chip_select_n && a_port_go && !a_write_not_read;
    b_wr = !b_chip_select_n && b_port_go && b_write_not_read;
    b_rd = !b_chip_select_n && b_port_go && !b_write_not_read;
    b_mail = b_width_sel_1 && b_width_sel_0;
    size = st_r.size_app[2:1];
    last = bfp_last_lane(size);
    // top lane in use on the bus, the only lanes parity-checked
    chk = (size == SIZE_BYTE) ? 2'h0 : ((size == SIZE_WORD) ? 2'h1 : 2'h3);
    swap_live = {swap_sel_1, swap_sel_0};

    // preset offset on the first edge after reset release
    if (!st_r.ofs_loaded)
    begin
      st_nxt.ofs_loaded = 1'b1;
      case ({offset_pick_1, offset_pick_0})
        2'h3: st_nxt.ofs = OFFSET_PRESET_HH;
        2'h2: st_nxt.ofs = OFFSET_PRESET_HL;
        2'h1: st_nxt.ofs = OFFSET_PRESET_LH;
        default: st_nxt.ofs = OFFSET_PRESET_LL;
      endcase
    end

    // size and endian captured, then applied one edge later
    st_nxt.size_cap = {b_width_sel_1, b_width_sel_0, big_endian_sel};
    st_nxt.size_app = st_r.size_cap;

    // ---- port a ----
    // a-to-b push needs the synchronised full flag high
    if (a_wr && !a_mailbox_select && st_r.a_s2.full_n
        && ab_cnt != FIFO_FULL_CNT)
    begin
      ab_push = 1'b1;
      st_nxt.ab_wp = st_r.ab_wp + 7'h01;
    end
    // b-to-a pop needs the synchronised empty flag high
    if (a_rd && !a_mailbox_select && st_r.a_s2.empty_n
        && ba_cnt != 7'h00)
    begin
      ba_pop = 1'b1;
      st_nxt.ba_rp = st_r.ba_rp + 7'h01;
    end
    // mailbox read by port a frees b-to-a mailbox
    if (a_rd && a_mailbox_select)
    begin
      st_nxt.mail2_full_n = 1'b1;
    end
    // mailbox write only while empty; set beats a same-cycle read
    if (a_wr && a_mailbox_select && st_r.mail1_full_n)
    begin
      st_nxt.mail1 = a_din;
      st_nxt.mail1_full_n = 1'b0;
    end

    // ---- port b write ----
    swap_eff = (st_r.wr_lane == 2'h0) ? swap_live : st_r.wr_swap;
    lane_eff = st_r.size_app[0] ? last - st_r.wr_lane : st_r.wr_lane;
    hold = st_r.wr_hold;
    case (size)
      SIZE_BYTE: hold[lane_eff*9 +: 9] = b_din[8:0];
      SIZE_WORD: hold[lane_eff[0]*18 +: 18] = b_din[17:0];
      default: hold = b_din;
    endcase
    ba_wdata = bfp_swap(hold, swap_eff);
    if (b_wr && !b_mail)
    begin
      st_nxt.wr_hold = hold;
      st_nxt.wr_swap = swap_eff;
      if (st_r.wr_lane >= last)
      begin
        // whole long word assembled; dropped if full
        st_nxt.wr_lane = 2'h0;
        if (st_r.b_s2.full_n && ba_cnt != FIFO_FULL_CNT)
        begin
          ba_push = 1'b1;
          st_nxt.ba_wp = st_r.ba_wp + 7'h01;
        end
      end
      else
      begin
        st_nxt.wr_lane = st_r.wr_lane + 2'h1;
      end
    end

    // ---- port b read ----
    if (b_rd && !b_mail)
    begin
      if (st_r.rd_lane >= last)
      begin
        // next long word; ignored while empty
        if (st_r.b_s2.empty_n && ab_cnt != 7'h00)
        begin
          ab_pop = 1'b1;
          st_nxt.ab_rp = st_r.ab_rp + 7'h01;
          st_nxt.rd_lane = 2'h0;
          st_nxt.rd_swap = swap_live;
        end
      end
      else
      begin
        st_nxt.rd_lane = st_r.rd_lane + 2'h1;
      end
    end
    // mailbox traffic on port b
    if (b_rd && b_mail)
    begin
      st_nxt.mail1_full_n = 1'b1;
    end
    if (a_wr && a_mailbox_select && st_r.mail1_full_n)
    begin
      st_nxt.mail1_full_n = 1'b0;
    end
    if (b_wr && b_mail && st_r.mail2_full_n)
    begin
      st_nxt.mail2 = b_din;
      st_nxt.mail2_full_n = 1'b0;
    end

    // ---- port a output path ----
    word = a_mailbox_select ? st_r.mail2 : ba_rdata;
    if (a_parity_gen_on)
    begin
      word = bfp_par_fill(word, odd_parity_sel);
    end
    st_nxt.a_dout = word;
    st_nxt.a_doe = !a_chip_select_n && !a_write_not_read;

    // ---- port b output path ----
    if (b_mail)
    begin
      pick = st_r.mail1;
    end
    else
    begin
      word = bfp_swap(ab_rdata, st_r.rd_swap);
      lane_eff = st_r.size_app[0] ? last - st_r.rd_lane : st_r.rd_lane;
      case (size)
        SIZE_BYTE: pick = {27'h000_0000, word[lane_eff*9 +: 9]};
        SIZE_WORD: pick = {18'h0_0000, word[lane_eff[0]*18 +: 18]};
        default: pick = word;
      endcase
    end
    if (b_parity_gen_on)
    begin
      pick = bfp_par_fill(pick, odd_parity_sel);
    end
    st_nxt.b_dout = pick;
    st_nxt.b_doe = !b_chip_select_n && !b_write_not_read;

    // ---- parity checks ----
    st_nxt.a_pfault_n = !bfp_lane_fail(a_din, odd_parity_sel, 2'h3);
    if (!a_write_not_read && a_mailbox_select && a_parity_gen_on)
    begin
      st_nxt.a_pfault_n = 1'b1;
    end
    // lanes beyond the applied bus size are not checked
    st_nxt.b_pfault_n = !bfp_lane_fail(b_din, odd_parity_sel,
                                       chk);
    if (!b_write_not_read && b_mail && b_parity_gen_on)
    begin
      st_nxt.b_pfault_n = 1'b1;
    end

    // ---- flags: raw from pointers, then two stages ----
    st_nxt.a_s1.full_n = ab_cnt != FIFO_FULL_CNT;
    st_nxt.a_s1.afull_n = ab_cnt < (FIFO_FULL_CNT - st_r.ofs);
    st_nxt.a_s1.empty_n = ba_cnt != 7'h00;
    st_nxt.a_s1.aempty_n = ba_cnt > st_r.ofs;
    st_nxt.b_s1.full_n = ba_cnt != FIFO_FULL_CNT;
    st_nxt.b_s1.afull_n = ba_cnt < (FIFO_FULL_CNT - st_r.ofs);
    st_nxt.b_s1.empty_n = ab_cnt != 7'h00;
    st_nxt.b_s1.aempty_n = ab_cnt > st_r.ofs;
    st_nxt.a_s2 = st_r.a_s1;
    st_nxt.b_s2 = st_r.b_s1;
  end

  // ============================================================
  // state register, reset at any time
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= ST_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ============================================================
  // outputs, all straight from the state register
  assign a_dout = st_r.a_dout;
  assign a_doe = st_r.a_doe;
  assign a_side_full_n = st_r.a_s2.full_n;
  assign a_side_empty_n = st_r.a_s2.empty_n;
  assign a_side_almost_empty_n = st_r.a_s2.aempty_n;
  assign a_side_almost_full_n = st_r.a_s2.afull_n;
  assign a_side_parity_fault_n = st_r.a_pfault_n;
  assign b_dout = st_r.b_dout;
  assign b_doe = st_r.b_doe;
  assign b_side_full_n = st_r.b_s2.full_n;
  assign b_side_empty_n = st_r.b_s2.empty_n;
  assign b_side_almost_empty_n = st_r.b_s2.aempty_n;
  assign b_side_almost_full_n = st_r.b_s2.afull_n;
  assign b_side_parity_fault_n = st_r.b_pfault_n;
  assign a_to_b_mail_full_n = st_r.mail1_full_n;
  assign b_to_a_mail_full_n = st_r.mail2_full_n;
endmodule
`default_nettype wire

// ===== test/bfp_port_ctrl_sva.sv
// concurrent checks on the pins of the port control
`timescale 1ns/1ps
`default_nettype none
module bfp_port_ctrl_sva
  import bfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic odd_parity_sel,
  input wire logic a_chip_select_n,
  input wire logic a_write_not_read,
  input wire logic a_port_go,
  input wire logic a_mailbox_select,
  input wire logic a_doe,
  input wire logic a_side_full_n,
  input wire logic a_side_empty_n,
  input wire logic a_side_almost_empty_n,
  input wire logic a_side_almost_full_n,
  input wire logic b_chip_select_n,
  input wire logic b_write_not_read,
  input wire logic b_port_go,
  input wire logic b_width_sel_0,
  input wire logic b_width_sel_1,
  input wire logic b_parity_gen_on,
  input wire logic [35:0] b_din,
  input wire logic b_side_full_n,
  input wire logic b_side_parity_fault_n,
  input wire logic a_to_b_mail_full_n,
  input wire logic b_to_a_mail_full_n
);
  // every lane of the port b input meets the selected sense
  wire logic lanes_ok = (^b_din[8:0] == odd_parity_sel)
    && (^b_din[17:9] == odd_parity_sel)
    && (^b_din[26:18] == odd_parity_sel)
    && (^b_din[35:27] == odd_parity_sel);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // size pins held long enough to be applied
  sequence s_long;
    (!b_width_sel_0 && !b_width_sel_1) [*3];
  endsequence
  sequence s_mail;
    (b_width_sel_0 && b_width_sel_1) [*3];
  endsequence
  // ============================================================
  // assertions
  a_rst_flags: assert property (disable iff (1'b0)
    !arst_n |-> !a_side_full_n && !a_side_empty_n && !a_side_almost_empty_n
    && a_side_almost_full_n && a_to_b_mail_full_n && b_to_a_mail_full_n)
    else $error("flag defaults wrong in reset");
  a_full_rise: assert property (
    $rose(arst_n) |-> !a_side_full_n ##2 (a_side_full_n && b_side_full_n))
    else $error("full flags not high two edges after reset");
  a_doe_on: assert property (
    !a_chip_select_n && !a_write_not_read |=> a_doe)
    else $error("port a not driving on read select");
  a_mail_force: assert property (
    s_mail ##0 (!b_write_not_read && b_parity_gen_on)
    |=> b_side_parity_fault_n) else $error("fault not forced high");
  a_fault_chk: assert property (
    s_long |=> b_side_parity_fault_n == $past(lanes_ok))
    else $error("port b parity fault wrong");
  a_b_mail_wr: assert property (
    s_mail ##0 (!b_chip_select_n && b_port_go && b_write_not_read
    && b_to_a_mail_full_n)
    |=> !b_to_a_mail_full_n) else $error("port b mail write lost");
  a_a_mail_wr: assert property (
    !a_chip_select_n && a_port_go && a_write_not_read && a_mailbox_select
    && a_to_b_mail_full_n
    |=> !a_to_b_mail_full_n) else $error("port a mail write lost");
  a_go_idle: assert property (
    !a_port_go && !b_port_go
    |=> $stable({a_to_b_mail_full_n, b_to_a_mail_full_n}))
    else $error("mail flag moved with both ports idle");
endmodule
bind bfp_port_ctrl bfp_port_ctrl_sva chk_u (.*);
`default_nettype wire

// ===== test/bfp_b_master.sv
// port b master model: word and mailbox transfers on port b
`timescale 1ns/1ps
`default_nettype none
module bfp_b_master
  import bfp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [35:0] b_dout,
  output var logic b_chip_select_n,
  output var logic b_write_not_read,
  output var logic b_port_go,
  output var logic b_width_sel_0,
  output var logic b_width_sel_1,
  output var logic big_endian_sel,
  output var logic swap_sel_0,
  output var logic swap_sel_1,
  output var logic [35:0] b_din
);
  // idle from time zero: deselected, long words, no swap
  initial
  begin
    b_chip_select_n = 1'b1;
    b_write_not_read = 1'b1;
    b_port_go = 1'b0;
    {b_width_sel_1, b_width_sel_0} = SIZE_LONG;
    big_endian_sel = 1'b0;
    {swap_sel_1, swap_sel_0} = SWAP_NONE;
    b_din = 36'h0_0000_0000;
  end
  // new bus size, then wait until it is applied
  task automatic set_size(input logic [1:0] s);
    @(negedge clk_sys);
    {b_width_sel_1, b_width_sel_0} = s;
    repeat (3) @(negedge clk_sys);
  endtask
  // one access held over one edge; read data two edges on
  task automatic xfer(input logic wr, input logic [35:0] d,
    output logic [35:0] q);
    @(negedge clk_sys);
    b_din = d;
    b_write_not_read = wr;
    b_chip_select_n = 1'b0;
    b_port_go = 1'b1;
    @(negedge clk_sys);
    b_port_go = 1'b0;
    b_din = ~d; // released lines do not keep the value
    repeat (2) @(negedge clk_sys);
    q = b_dout;
  endtask
  // swap pins for the next long word
  task automatic set_swap(input logic [1:0] m);
    @(negedge clk_sys);
    {swap_sel_1, swap_sel_0} = m;
  endtask
  // data lines only, no request
  task automatic drive(input logic [35:0] d);
    @(negedge clk_sys);
    b_din = d;
  endtask
endmodule
`default_nettype wire

// ===== test/bfp_port_ctrl_tb.sv
// testbench: port control against queue models and a port b master
`timescale 1ns/1ps
`default_nettype none
module bfp_port_ctrl_tb
  import bfp_pkg::*;
;
  logic clk_sys, arst_n, odd_parity_sel, offset_pick_0, offset_pick_1;
  logic a_chip_select_n, a_write_not_read, a_port_go, a_mailbox_select;
  logic a_parity_gen_on, a_doe, a_side_full_n, a_side_empty_n;
  logic a_side_almost_empty_n, a_side_almost_full_n, a_side_parity_fault_n;
  logic b_chip_select_n, b_write_not_read, b_port_go, b_width_sel_0;
  logic b_width_sel_1, big_endian_sel, swap_sel_0, swap_sel_1;
  logic b_parity_gen_on, b_doe, b_side_full_n, b_side_empty_n;
  logic b_side_almost_empty_n, b_side_almost_full_n, b_side_parity_fault_n;
  logic a_to_b_mail_full_n, b_to_a_mail_full_n;
  logic [35:0] a_din, a_dout, b_din, b_dout, w, e;
  logic [35:0] ab_q[$], ba_q[$]; // queue models
  int n_mismatch, n_tests, k;
  bfp_port_ctrl dut_u (.*);
  bfp_b_master bm_u (.*);
  always #5 clk_sys = ~clk_sys; // 100 MHz
  // generated parity into bit 8 of each lane when g is set
  function automatic logic [35:0] fill(input logic [35:0] v,
    input logic g);
    fill = v;
    for (int i = 0; i < 4; i++)
      if (g)
        fill[i*9+8] = (^v[i*9 +: 8]) ^ odd_parity_sel;
  endfunction
  // high when every lane meets the selected sense
  function automatic logic good(input logic [35:0] v);
    good = 1'b1;
    for (int i = 0; i < 4; i++)
      if ((^v[i*9 +: 9]) != odd_parity_sel)
        good = 1'b0;
  endfunction
  task automatic cmp(input string nm, input logic [35:0] x,
    input logic [35:0] g);
    n_tests++;
    if (g !== x)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one port a access held over one edge
  task automatic a_op(input logic wr, input logic mb, input logic [35:0] d);
    @(negedge clk_sys);
    a_chip_select_n = 1'b0;
    a_write_not_read = wr;
    a_mailbox_select = mb;
    a_din = d;
    a_port_go = 1'b1;
    @(negedge clk_sys);
    a_port_go = 1'b0;
    a_din = ~d;
  endtask
  // ============================================================
  // main sequence
  initial
  begin
    clk_sys = 1'b0;
    arst_n = 1'b1; // dropped at 1 ns so the reset edge is seen
    {offset_pick_1, offset_pick_0} = 2'($urandom(92985));
    {odd_parity_sel, a_parity_gen_on, b_parity_gen_on} = 3'h0;
    {a_chip_select_n, a_write_not_read, a_port_go} = 3'h6;
    a_mailbox_select = 1'b0;
    a_din = 36'h0_0000_0000;
    n_mismatch = 0;
    n_tests = 0;
    #1 arst_n = 1'b0;
    repeat (16) @(negedge clk_sys);
    cmp("reset flags", 36'h0_0000_0047, 36'({a_side_full_n, a_side_empty_n,
      a_side_almost_empty_n, a_side_almost_full_n, b_side_full_n,
      b_side_empty_n, b_side_almost_empty_n, b_side_almost_full_n,
      a_to_b_mail_full_n, b_to_a_mail_full_n}));
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp("full", 36'h3, 36'({a_side_full_n, b_side_full_n}));
    $display("reset test done");
    odd_parity_sel = 1'($urandom());
    b_parity_gen_on = 1'($urandom());
    for (k = 0; k < 4; k++)
    begin
      w = {4'($urandom()), $urandom()};
      a_op(1'b1, 1'b0, w);
      ab_q.push_back(w);
    end
    repeat (4) @(negedge clk_sys);
    for (k = 0; k < 4; k++)
    begin
      bm_u.xfer(1'b0, w, e);
      cmp("b read", fill(ab_q.pop_front(), b_parity_gen_on), e);
    end
    cmp("b drive", 36'h1, 36'(b_doe));
    $display("a to b test done");
    a_parity_gen_on = 1'($urandom());
    for (k = 0; k < 4; k++)
    begin
      w = {4'($urandom()), $urandom()};
      bm_u.set_swap(k == 3 ? SWAP_WORD : SWAP_NONE);
      bm_u.xfer(1'b1, w, e);
      ba_q.push_back(k == 3 ? {w[17:0], w[35:18]} : w);
    end
    for (k = 0; k < 4; k++)
    begin
      a_op(1'b0, 1'b0, w);
      repeat (2) @(negedge clk_sys);
      cmp("a read", fill(ba_q.pop_front(), a_parity_gen_on), a_dout);
    end
    cmp("a drive", 36'h1, 36'(a_doe));
    a_write_not_read = 1'b1;
    a_din = ~w;
    repeat (8) @(negedge clk_sys);
    cmp("a drive", 36'h0, 36'(a_doe));
    cmp("b empty", 36'h0, 36'(b_side_empty_n));
    $display("b to a test done");
    for (k = 0; k < 8; k++)
    begin
      odd_parity_sel = 1'($urandom());
      w = {4'($urandom()), $urandom()};
      if (k[0])
        w = fill(w, 1'b1);
      a_din = w;
      bm_u.drive(w);
      @(negedge clk_sys);
      cmp("b fault", 36'(good(w)), 36'(b_side_parity_fault_n));
      cmp("a fault", 36'(good(w)), 36'(a_side_parity_fault_n));
    end
    bm_u.set_size(SIZE_BYTE);
    w = fill({4'($urandom()), $urandom()}, 1'b1) ^ 36'h0_0002_0000;
    bm_u.drive(w);
    @(negedge clk_sys);
    cmp("byte fault", 36'h1, 36'(b_side_parity_fault_n));
    $display("parity test done");
    bm_u.set_size(SIZE_MAIL);
    b_parity_gen_on = 1'b1;
    w = {4'($urandom()), $urandom()};
    a_op(1'b1, 1'b1, w);
    cmp("mail1 flag", 36'h0, 36'(a_to_b_mail_full_n));
    bm_u.xfer(1'b0, w, e);
    cmp("mail1 data", fill(w, 1'b1), e);
    cmp("mail1 flag", 36'h1, 36'(a_to_b_mail_full_n));
    bm_u.drive(fill(w, 1'b1) ^ 36'h0_0000_0001);
    @(negedge clk_sys);
    cmp("mail fault", 36'h1, 36'(b_side_parity_fault_n));
    w = {4'($urandom()), $urandom()};
    bm_u.xfer(1'b1, w, e);
    cmp("mail2 flag", 36'h0, 36'(b_to_a_mail_full_n));
    a_op(1'b0, 1'b1, w);
    repeat (2) @(negedge clk_sys);
    cmp("mail2 data", fill(w, a_parity_gen_on), a_dout);
    cmp("mail2 flag", 36'h1, 36'(b_to_a_mail_full_n));
    $display("mailbox test done");
    // reset again, dropped between clock edges
    #3 arst_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    cmp("mid reset", 36'h0, 36'({a_side_full_n, b_side_full_n}));
    arst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    cmp("full", 36'h3, 36'({a_side_full_n, b_side_full_n}));
    $display("reset again test done");
    conclude();
  end
  // hang guard, far beyond the 140 or so cycles needed
  initial
  begin
    #20000;
    n_mismatch++;
    $display("BAD watchdog expected done seen hang");
    conclude();
  end
endmodule
`default_nettype wire
